/* dv/alu_core_checker.sv */
/*
 * Concurrent checks on the add-and-flags slice, bound to alu_core.
 * Assumes one clock domain and an APB master with legal spacing.
 */
`timescale 1ns/1ps

module alu_core_checker (
    input wire logic        mclk_i,    // Clock
    input wire logic        rst_i,     // Sync reset
    input wire logic        psel_i,    // APB select
    input wire logic        penable_i, // APB access
    input wire logic        pwrite_i,  // APB write
    input wire logic [7:0]  paddr_i,   // APB address
    input wire logic [31:0] pwdata_i,  // APB write data
    input wire logic [31:0] prdata_o,  // APB read data
    input wire logic        pready_o,  // APB ready
    input wire logic        pslverr_o, // APB error
    input wire logic [15:0] acc_o,     // Accumulator
    input wire logic [5:0]  flags_o,   // Flags
    input wire logic        busy_o     // Executing
);
    // ------------------------------------------------------------
    // Operand shadow and launch-time snapshots
    // ------------------------------------------------------------
    logic [15:0] opnd_q;
    logic [15:0] acc_l;
    logic [5:0]  flg_l;
    logic        wr;
    logic        fwr;
    logic        launch;
    assign wr     = psel_i & penable_i & pwrite_i;
    assign fwr    = wr & (paddr_i == alu_pkg::OFS_FLAGS);
    assign launch = wr & (paddr_i == alu_pkg::OFS_CTRL) & ~busy_o;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            opnd_q <= 16'h0000;
        end else if (wr && paddr_i == alu_pkg::OFS_OPERAND) begin
            opnd_q <= pwdata_i[15:0];
        end
        if (launch) begin
            acc_l <= acc_o;
            flg_l <= flags_o;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_go(logic [2:0] op);
        launch && pwdata_i[2:0] == op;
    endsequence
    sequence s_exec;
        busy_o ##1 !busy_o;
    endsequence

    chk_err_map: assert property (pslverr_o == (psel_i && penable_i &&
        !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})))
        else $error("error response does not match address map");
    chk_busy_pulse: assert property (launch |=> s_exec)
        else $error("busy is not a single cycle after launch");
    chk_flags_cause: assert property ($changed(flags_o) |->
        $past(busy_o) || $past(fwr)) else $error("flags changed idle");
    chk_byte_add: assert property (s_go(3'h0) ##0 !pwdata_i[4] |->
        ##2 {flags_o[0], acc_o[7:0]} == {1'b0, acc_l[7:0]} + opnd_q[7:0]
        && flags_o[2] == (acc_l[4] ^ opnd_q[4] ^ acc_o[4])
        && acc_o[15:8] == acc_l[15:8]) else $error("byte add wrong");
    chk_word_ovf: assert property (s_go(3'h0) ##0 pwdata_i[4] |->
        ##2 {flags_o[0], acc_o} == {1'b0, acc_l} + opnd_q && flags_o[5] ==
        (acc_l[15] == opnd_q[15] && acc_o[15] != acc_l[15]))
        else $error("word add or overflow wrong");
    chk_byte_flags: assert property (launch && pwdata_i[2:0] < 3'h4 &&
        !pwdata_i[4] |-> ##2 flags_o[4] == acc_o[7] && flags_o[1] ==
        ~^acc_o[7:0] && flags_o[3] == (acc_o[7:0] == 8'h00))
        else $error("byte sign zero parity wrong");
    chk_word_flags: assert property (launch && pwdata_i[2:0] < 3'h4 &&
        pwdata_i[4] |-> ##2 flags_o[4] == acc_o[15] && flags_o[1] ==
        ~^acc_o[7:0] && flags_o[3] == (acc_o == 16'h0000))
        else $error("word sign zero parity wrong");
    chk_inc_carry: assert property (s_go(3'h2) |-> ##2
        flags_o[0] == flg_l[0] && acc_o[7:0] == acc_l[7:0] + 8'h01)
        else $error("increment disturbed carry");
    chk_unp_fix: assert property (s_go(3'h4) ##0 acc_o[3:0] > 4'h9
        |-> ##2 acc_o == {acc_l[15:8] + 8'h01, 4'h0, acc_l[3:0] + 4'h6}
        && flags_o[0] && flags_o[2]) else $error("digit fix wrong");
    chk_unp_keep: assert property (s_go(3'h4) ##0 acc_o[3:0] <= 4'h9 &&
        !flags_o[2] |-> ##2 acc_o == {acc_l[15:8], 4'h0, acc_l[3:0]}
        && flags_o[2:0] == {1'b0, flg_l[1], 1'b0})
        else $error("digit keep wrong");
endmodule // alu_core_checker

bind alu_core alu_core_checker i_alu_core_checker (.mclk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .acc_o, .flags_o, .busy_o);

/* dv/op_issuer_model.sv */
/*
 * APB master standing in for the instruction decoder and register file.
 * Assumes the bench supplies the clock and calls xfer for each access.
 */
`timescale 1ns/1ps

module op_issuer_model (
    input  wire logic        mclk_i,    // Bus clock
    input  wire logic        pready_i,  // Slave ready
    input  wire logic [31:0] prdata_i,  // Slave read data
    input  wire logic        pslverr_i, // Slave error
    output logic             psel_o,    // Select
    output logic             penable_o, // Access phase
    output logic             pwrite_o,  // Direction
    output logic      [7:0]  paddr_o,   // Byte address
    output logic      [31:0] pwdata_o   // Write data
);
    // ------------------------------------------------------------
    // One transfer; released lines show inverted data, not stale
    // ------------------------------------------------------------
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge mclk_i);
        psel_o   <= 1'b1;
        pwrite_o <= w;
        paddr_o  <= a;
        pwdata_o <= d;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        // Waits as long as the slave stalls; the bench watchdog ends a hang
        do begin
            @(posedge mclk_i);
        end while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        paddr_o   <= ~a;
        pwdata_o  <= ~d;
    endtask
endmodule // op_issuer_model

/* dv/test_integer_add_and_flags_alu.sv */
/*
 * Self-checking bench for alu_core: table of add-group operations,
 * then register map, chained carry and mid-run reset cases.
 * Assumes the partner model drives APB and the checker is bound.
 */
`timescale 1ns/1ps

module test_integer_add_and_flags_alu;
    typedef struct packed {
        logic [2:0]  op;
        logic        word;
        logic [15:0] acc;
        logic [15:0] src;
        logic [5:0]  fin;
        logic [15:0] eacc;
        logic [5:0]  eflg;
    } row_t;
    logic        mclk_i = 1'b0;
    logic        rst_i  = 1'b1;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, busy_o;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [15:0] acc_o;
    logic [5:0]  flags_o;
    logic        er;
    int          bad_count = 0;
    int          samples_checked = 0;
    row_t        rows [16];

    alu_core i_alu_core (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .acc_o,
        .flags_o, .busy_o);
    op_issuer_model i_op_issuer_model (.mclk_i, .pready_i(pready_o),
        .prdata_i(prdata_o), .pslverr_i(pslverr_o), .psel_o(psel_i),
        .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
        .pwdata_o(pwdata_i));

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        i_op_issuer_model.xfer(w, a, d, rd, er);
    endtask
    task automatic run_op(input logic [2:0] op, input logic w);
        int n;
        n = 0;
        bus(1'b1, alu_pkg::OFS_CTRL, {27'h0, w, 1'b0, op});
        do begin
            @(posedge mclk_i);
            n++;
        end while (busy_o !== 1'b1 && n < 20);
        while (busy_o !== 1'b0 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 20) bad_count++;
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        // Operands include low nibbles above nine, such as f, b and a
        rows = '{
        '{3'h0, 1'b0, 16'h12ff, 16'h0001, 6'h00, 16'h1200, 6'h0f},
        '{3'h0, 1'b0, 16'h007f, 16'h0001, 6'h00, 16'h0080, 6'h34},
        '{3'h0, 1'b1, 16'h7fff, 16'h0001, 6'h00, 16'h8000, 6'h36},
        '{3'h0, 1'b1, 16'hffff, 16'h0001, 6'h00, 16'h0000, 6'h0f},
        '{3'h1, 1'b0, 16'h0005, 16'h0003, 6'h01, 16'h0009, 6'h02},
        '{3'h1, 1'b1, 16'h1234, 16'h0001, 6'h00, 16'h1235, 6'h02},
        '{3'h2, 1'b0, 16'h000f, 16'h0000, 6'h01, 16'h0010, 6'h05},
        '{3'h2, 1'b1, 16'hffff, 16'h0000, 6'h00, 16'h0000, 6'h0e},
        '{3'h3, 1'b0, 16'h0010, 16'h0001, 6'h00, 16'h000f, 6'h06},
        '{3'h3, 1'b0, 16'h0000, 16'h0001, 6'h00, 16'h00ff, 6'h17},
        '{3'h3, 1'b0, 16'h0080, 16'h0001, 6'h00, 16'h007f, 6'h24},
        '{3'h4, 1'b0, 16'h010b, 16'h0000, 6'h00, 16'h0201, 6'h05},
        '{3'h4, 1'b1, 16'h0035, 16'h0000, 6'h03, 16'h0005, 6'h02},
        '{3'h5, 1'b0, 16'h009a, 16'h0000, 6'h00, 16'h0000, 6'h0f},
        '{3'h5, 1'b0, 16'h0045, 16'h0000, 6'h20, 16'h0045, 6'h20},
        '{3'h6, 1'b0, 16'h0307, 16'h0000, 6'h00, 16'h0025, 6'h00}};
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, alu_pkg::OFS_ACC, {16'h0, rows[i].acc});
            bus(1'b1, alu_pkg::OFS_OPERAND, {16'h0, rows[i].src});
            bus(1'b1, alu_pkg::OFS_FLAGS, {26'h0, rows[i].fin});
            run_op(rows[i].op, rows[i].word);
            check("acc", {16'h0, acc_o}, {16'h0, rows[i].eacc});
            check("flags", {26'h0, flags_o}, {26'h0, rows[i].eflg});
            $display("test %0d done", i);
        end
        // Register map: status count, read-only write, unmapped places
        bus(1'b0, alu_pkg::OFS_STATUS, 32'h0);
        check("status", rd, 32'h0010_0000);
        bus(1'b0, alu_pkg::OFS_CTRL, 32'h0);
        check("ctrl rd", rd, 32'h0000_0006);
        bus(1'b1, alu_pkg::OFS_STATUS, 32'hffff_ffff);
        check("ro err", {31'h0, er}, 32'h0);
        bus(1'b1, 8'h14, 32'h0000_0001);
        check("unmapped wr", {31'h0, er}, 32'h1);
        bus(1'b0, 8'h02, 32'h0);
        check("unmapped rd", {31'h0, er}, 32'h1);
        $display("test map done");
        // Chained byte add then add with carry
        bus(1'b1, alu_pkg::OFS_ACC, 32'h0000_00ff);
        bus(1'b1, alu_pkg::OFS_OPERAND, 32'h0000_0001);
        run_op(3'h0, 1'b0);
        check("chain flags", {26'h0, flags_o}, 32'h0000_000f);
        bus(1'b1, alu_pkg::OFS_OPERAND, 32'h0);
        run_op(3'h1, 1'b0);
        bus(1'b0, alu_pkg::OFS_ACC, 32'h0);
        check("chain acc", rd, 32'h0000_0001);
        check("chain flg", {26'h0, flags_o}, 32'h0);
        $display("test chain done");
        // Reset in mid-run clears state and op count
        bus(1'b1, alu_pkg::OFS_FLAGS, 32'h0000_003f);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        check("rst acc", {16'h0, acc_o}, 32'h0);
        check("rst flags", {26'h0, flags_o}, 32'h0);
        check("rst busy", {31'h0, busy_o}, 32'h0);
        bus(1'b0, alu_pkg::OFS_STATUS, 32'h0);
        check("rst status", rd, 32'h0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // test_integer_add_and_flags_alu

/* hdl/alu_core.sv */
/*
 * Add-group datapath slice with accumulator, six status flags and an
 * APB register slave. Binary ops write the accumulator from itself and
 * the operand register; decimal adjusts work on its low and high bytes.
 * Assumes an APB master on mclk_i and a synchronous active-high reset.
 */
// Our own choices: the APB slave port and the placing of the registers.
// What this block does
// - Operands are byte or word per operation, result of same width.
// - Signed values are two's complement, top bit is the sign.
// - Packed decimal byte: one digit per nibble, upper more significant.
// - Packed decimal sums: binary add to low byte, then adjust step.
// - Numerator adjust fixes the low byte before a later divide.
// - Unpacked adjusts leave the upper nibble of the result at zero.
// - Addition sets carry on carry out of the top bit.
// - Subtraction sets carry on borrow into the top bit.
// - Half carry marks carry out of or borrow into low nibble.
// - Sign copies bit 7 for bytes, bit 15 for words.
// - Zero is set when the whole result is zero.
// - Parity set when low eight result bits hold even ones.
// - Overflow set when the signed result does not fit.
// - Add writes the sum and updates all six flags.
// - Add with carry adds carry in, writes, updates all flags.
// - Increment adds one, keeps carry, updates the other five.
// - Unpacked adjust gives a valid digit, updates carry, half carry.
// - Packed adjust gives two digits, updates all but overflow.
`timescale 1ns/1ps

module alu_core (
    input  wire logic        mclk_i,    // 200 MHz clock
    input  wire logic        rst_i,     // Sync reset, active high
    input  wire logic        psel_i,    // APB select
    input  wire logic        penable_i, // APB access phase
    input  wire logic        pwrite_i,  // APB write
    input  wire logic [7:0]  paddr_i,   // APB byte address
    input  wire logic [31:0] pwdata_i,  // APB write data
    output logic      [31:0] prdata_o,  // APB read data
    output logic             pready_o,  // APB ready
    output logic             pslverr_o, // APB error
    output logic      [15:0] acc_o,     // Accumulator
    output logic      [5:0]  flags_o,   // Status flags
    output logic             busy_o     // Operation in flight
);

    // ------------------------------------------------------------
    // State and adder hook-up
    // ------------------------------------------------------------
    alu_pkg::core_state_t s;
    alu_pkg::core_state_t next_s;

    alu_flag_if fi ();

    flag_gen u_flag_gen (
        .fi (fi.gen)
    );

    // Parity, sign and zero of a byte result
    function automatic alu_pkg::flags_t byte_psz(
        input alu_pkg::flags_t f,
        input logic [7:0]      v
    );
        alu_pkg::flags_t g;
        g = f;
        g.parity_flag = ~^v;
        g.sign_flag   = v[7];
        g.zero_flag   = (v == 8'h00);
        return g;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic [7:0] al;
    logic [7:0] ah;
    logic [7:0] al_fix;
    logic       lo_bad;
    logic       hi_bad;
    logic       setup;
    logic       wr_acc;

    always_comb begin
        next_s = s;
        al     = s.acc[7:0];
        ah     = s.acc[15:8];
        al_fix = al;
        setup  = psel_i && !penable_i;
        wr_acc = psel_i && penable_i && pwrite_i;

        // Operand routing into the shared adder
        fi.a    = s.acc;
        fi.b    = s.operand;
        fi.cin  = 1'b0;
        fi.sub  = 1'b0;
        fi.word = s.word;
        case (s.op)
            alu_pkg::OP_ADC: begin
                fi.cin = s.flags.carry_flag;
            end
            alu_pkg::OP_INC: begin
                fi.b = alu_pkg::INC_STEP;
            end
            alu_pkg::OP_SUB: begin
                fi.sub = 1'b1;
            end
            default: begin
                fi.cin = 1'b0;
            end
        endcase

        // Low digit needs fixing when above nine or half carry is up
        lo_bad = (al[3:0] > alu_pkg::DIGIT_MAX)
              || s.flags.half_carry_flag;
        hi_bad = (al > alu_pkg::PACKED_MAX) || s.flags.carry_flag;

        // --------------------------------------------------------
        // APB: read data and error latched in the setup cycle
        // --------------------------------------------------------
        if (setup) begin
            next_s.err   = 1'b0;
            next_s.rdata = 32'h0000_0000;
            case (paddr_i)
                alu_pkg::OFS_OPERAND: begin
                    next_s.rdata = {16'h0000, s.operand};
                end
                alu_pkg::OFS_ACC: begin
                    next_s.rdata = {16'h0000, s.acc};
                end
                alu_pkg::OFS_FLAGS: begin
                    next_s.rdata = {26'h000_0000, s.flags};
                end
                alu_pkg::OFS_CTRL: begin
                    next_s.rdata = {27'h000_0000, s.word, 1'b0, s.op};
                end
                alu_pkg::OFS_STATUS: begin
                    next_s.rdata = {s.exec_count, 15'h0000,
                                    (s.fsm == alu_pkg::ST_EXEC)};
                end
                default: begin
                    next_s.err = 1'b1;
                end
            endcase
        end

        // Writes take effect at the access-phase edge
        if (wr_acc) begin
            case (paddr_i)
                alu_pkg::OFS_OPERAND: begin
                    next_s.operand = pwdata_i[15:0];
                end
                alu_pkg::OFS_ACC: begin
                    next_s.acc = pwdata_i[15:0];
                end
                alu_pkg::OFS_FLAGS: begin
                    next_s.flags = alu_pkg::flags_t'(pwdata_i[5:0]);
                end
                alu_pkg::OFS_CTRL: begin
                    // A launch while busy is dropped, not queued
                    if (s.fsm == alu_pkg::ST_IDLE) begin
                        next_s.op   = alu_pkg::op_t'(pwdata_i[2:0]);
                        next_s.word = pwdata_i[alu_pkg::CTRL_WORD_BIT];
                        next_s.fsm  = alu_pkg::ST_EXEC;
                    end
                end
                default: begin
                    next_s.err = s.err;
                end
            endcase
        end

        // --------------------------------------------------------
        // Execution: accumulator and flags land on the same edge;
        // placed after the APB writes so it wins over a same-cycle software write
        // --------------------------------------------------------
        case (s.fsm)
            alu_pkg::ST_IDLE: begin
                next_s.fsm = next_s.fsm;
            end
            alu_pkg::ST_EXEC: begin
                next_s.fsm        = alu_pkg::ST_IDLE;
                next_s.exec_count = s.exec_count + 16'h0001;
                case (s.op)
                    alu_pkg::OP_ADD,
                    alu_pkg::OP_ADC,
                    alu_pkg::OP_SUB: begin
                        // Byte ops keep the high accumulator byte
                        next_s.acc = s.word ? fi.sum
                                            : {ah, fi.sum[7:0]};
                        next_s.flags = fi.flags;
                    end
                    alu_pkg::OP_INC: begin
                        next_s.acc = s.word ? fi.sum
                                            : {ah, fi.sum[7:0]};
                        next_s.flags = fi.flags;
                        next_s.flags.carry_flag =
                            s.flags.carry_flag;
                    end
                    alu_pkg::OP_UNP_ADJ: begin
                        // Overflow, parity, sign, zero left as they were
                        if (lo_bad) begin
                            al_fix = al + alu_pkg::LOW_FIX;
                            next_s.acc = {ah + alu_pkg::BYTE_ONE,
                                          4'h0, al_fix[3:0]};
                            next_s.flags.carry_flag      = 1'b1;
                            next_s.flags.half_carry_flag = 1'b1;
                        end else begin
                            next_s.acc = {ah, 4'h0, al[3:0]};
                            next_s.flags.carry_flag      = 1'b0;
                            next_s.flags.half_carry_flag = 1'b0;
                        end
                    end
                    alu_pkg::OP_PCK_ADJ: begin
                        // Low byte holds a binary sum of two digit pairs
                        if (lo_bad) begin
                            al_fix = al + alu_pkg::LOW_FIX;
                        end
                        if (hi_bad) begin
                            al_fix = al_fix + alu_pkg::HIGH_FIX;
                        end
                        next_s.acc   = {ah, al_fix};
                        next_s.flags = byte_psz(s.flags, al_fix);
                        next_s.flags.half_carry_flag = lo_bad;
                        next_s.flags.carry_flag      = hi_bad;
                    end
                    alu_pkg::OP_NUM_ADJ: begin
                        // High digit times ten plus low digit, 8 bits
                        al_fix = {ah[4:0], 3'h0} + {ah[6:0], 1'b0}
                               + al;
                        next_s.acc   = {8'h00, al_fix};
                        next_s.flags = byte_psz(s.flags, al_fix);
                    end
                    default: begin
                        next_s.acc = s.acc;
                    end
                endcase
            end
            default: begin
                next_s.fsm = alu_pkg::ST_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // Reset
        // --------------------------------------------------------
        if (rst_i) begin
            next_s.fsm        = alu_pkg::ST_IDLE;
            next_s.operand    = alu_pkg::OPERAND_RST;
            next_s.acc        = alu_pkg::ACC_RST;
            next_s.flags      = alu_pkg::FLAGS_RST;
            next_s.op         = alu_pkg::OP_NONE;
            next_s.word       = 1'b0;
            next_s.exec_count = 16'h0000;
            next_s.rdata      = 32'h0000_0000;
            next_s.err        = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read data was fetched in setup, so no wait state is needed
    assign pready_o  = 1'b1;
    assign prdata_o  = s.rdata;
    assign pslverr_o = s.err && psel_i && penable_i;
    assign acc_o     = s.acc;
    assign flags_o   = s.flags;
    assign busy_o    = (s.fsm == alu_pkg::ST_EXEC);

endmodule // alu_core

/* hdl/alu_flag_if.sv */
/*
 * Bundle between the datapath core and its adder/flag generator.
 * Assumes both ends sit in the same clock domain; purely combinational.
 */
`timescale 1ns/1ps

interface alu_flag_if;
    logic [15:0]     a;
    logic [15:0]     b;
    logic            cin;
    logic            sub;
    logic            word;
    logic [15:0]     sum;
    alu_pkg::flags_t flags;

    modport core (output a, b, cin, sub, word, input sum, flags);
    modport gen  (input a, b, cin, sub, word, output sum, flags);
endinterface

/* hdl/alu_pkg.sv */
/*
 * Shared constants and types of the add-and-flags datapath: register
 * map, control fields, opcodes, flag layout and state record.
 * Assumes a 32-bit APB register bus and a byte-addressed paddr.
 */
package alu_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam logic [7:0]  OFS_OPERAND = 8'h00;
    localparam logic [7:0]  OFS_ACC     = 8'h04;
    localparam logic [7:0]  OFS_FLAGS   = 8'h08;
    localparam logic [7:0]  OFS_CTRL    = 8'h0c;
    localparam logic [7:0]  OFS_STATUS  = 8'h10;

    // ------------------------------------------------------------
    // Control fields and arithmetic constants
    // ------------------------------------------------------------
    localparam int unsigned CTRL_WORD_BIT = 4;
    localparam logic [3:0]  DIGIT_MAX     = 4'h9;
    localparam logic [7:0]  LOW_FIX       = 8'h06;
    localparam logic [7:0]  HIGH_FIX      = 8'h60;
    localparam logic [7:0]  PACKED_MAX    = 8'h99;
    localparam logic [7:0]  BYTE_ONE      = 8'h01;
    localparam logic [15:0] INC_STEP      = 16'h0001;
    localparam logic [15:0] ACC_RST       = 16'h0000;
    localparam logic [15:0] OPERAND_RST   = 16'h0000;

    typedef enum logic [2:0] {
        OP_ADD      = 3'h0,
        OP_ADC      = 3'h1,
        OP_INC      = 3'h2,
        OP_SUB      = 3'h3,
        OP_UNP_ADJ  = 3'h4,
        OP_PCK_ADJ  = 3'h5,
        OP_NUM_ADJ  = 3'h6,
        OP_NONE     = 3'h7
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } fsm_t;

    // Bit 0 carry up to bit 5 overflow
    typedef struct packed {
        logic overflow_flag;
        logic sign_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic parity_flag;
        logic carry_flag;
    } flags_t;

    localparam flags_t FLAGS_RST = 6'h00;

    typedef struct packed {
        fsm_t        fsm;
        logic [15:0] operand;
        logic [15:0] acc;
        flags_t      flags;
        op_t         op;
        logic        word;
        logic [15:0] exec_count;
        logic [31:0] rdata;
        logic        err;
    } core_state_t;

endpackage

/* hdl/flag_gen.sv */
/*
 * Byte/word adder-subtractor and the six arithmetic flags it yields.
 * Assumes the core picks operands and keeps any flag it must preserve.
 */
`timescale 1ns/1ps

module flag_gen (
    alu_flag_if.gen fi    // Operands in, sum and flags out
);

    logic [15:0] a_m;
    logic [15:0] b_inv;
    logic [15:0] b_m;
    logic        cin_e;
    logic [16:0] total;
    logic [4:0]  nib;
    logic [15:0] r;

    always_comb begin
        // Byte mode clears the upper half so bit 8 is the byte carry
        a_m   = fi.word ? fi.a : {8'h00, fi.a[7:0]};
        b_inv = fi.sub ? ~fi.b : fi.b;
        b_m   = fi.word ? b_inv : {8'h00, b_inv[7:0]};
        cin_e = fi.cin ^ fi.sub;
        total = {1'b0, a_m} + {1'b0, b_m} + {16'h0000, cin_e};
        nib   = {1'b0, a_m[3:0]} + {1'b0, b_m[3:0]} + {4'h0, cin_e};
        r     = fi.word ? total[15:0] : {8'h00, total[7:0]};
        fi.sum = r;
        fi.flags.carry_flag = fi.word ? (total[16] ^ fi.sub)
                                      : (total[8] ^ fi.sub);
        fi.flags.half_carry_flag = nib[4] ^ fi.sub;
        fi.flags.sign_flag = fi.word ? r[15] : r[7];
        fi.flags.zero_flag = (r == 16'h0000);
        fi.flags.parity_flag = ~^r[7:0];
        // Two's complement: same input signs, different result sign
        fi.flags.overflow_flag = fi.word
            ? ((a_m[15] == b_m[15]) && (r[15] != a_m[15]))
            : ((a_m[7] == b_m[7]) && (r[7] != a_m[7]));
    end

endmodule // flag_gen
